// >>> hdl/scdp_pkg.sv
// Purpose: constants and types shared by the sensor conditioning datapath
// Assumes: coefficients and filter words come from nonvolatile words 0..9
// Notes:   all fixed point figures are named here

package scdp_pkg;

  // ***************************************************************
  // register map of the nonvolatile words
  // ***************************************************************
  localparam logic [3:0] COND_COEF_OFFSET_IDX     = 4'h0;
  localparam logic [3:0] COND_COEF_GAIN_IDX       = 4'h1;
  localparam logic [3:0] COND_COEF_SQUARE_IDX     = 4'h2;
  localparam logic [3:0] COND_COEF_CUBE_IDX       = 4'h3;
  localparam logic [3:0] COND_COEF_OFFSET_TC1_IDX = 4'h4;
  localparam logic [3:0] COND_COEF_OFFSET_TC2_IDX = 4'h5;
  localparam logic [3:0] COND_COEF_GAIN_TC1_IDX   = 4'h6;
  localparam logic [3:0] COND_COEF_GAIN_TC2_IDX   = 4'h7;
  localparam logic [3:0] FILTER_SHIFT_WORD_IDX    = 4'h8;
  localparam logic [3:0] FILTER_GAIN_WORD_IDX     = 4'h9;
  localparam int         NUM_WORDS                = 10;
  localparam logic [15:0] WORD_RESET              = 16'h0000;

  // ***************************************************************
  // field layout and fixed point figures
  // ***************************************************************
  localparam int FILT_FIELD_LSB  = 0;
  localparam int FILT_FIELD_W    = 3;
  localparam int RES_MIN         = 13;
  localparam int RES_MAX         = 16;
  localparam int RES_SEG_MIN     = 15;
  localparam int DIAG_RES        = 13;
  localparam int SEG_SHIFT       = 13;
  localparam int TEMP_DIV_SHIFT  = 2;
  localparam int LIN_SHIFT       = 15;
  localparam int FRAC_W          = 15;
  localparam int DAC_LEVELS      = 5632;
  localparam int ERR_BIT         = 15;

  // ***************************************************************
  // channel kinds of an incoming result
  // ***************************************************************
  typedef enum logic [2:0] {
    SCDP_CH_BRIDGE = 3'b001,
    SCDP_CH_TEMP   = 3'b010,
    SCDP_CH_DIAG   = 3'b100
  } scdp_chan_t;

  typedef enum logic [3:0] {
    SCDP_IDLE = 4'b0001,
    SCDP_DIV  = 4'b0010,
    SCDP_LIN  = 4'b0100,
    SCDP_OUT  = 4'b1000
  } scdp_state_t;

endpackage : scdp_pkg

// >>> hdl/scdp_datapath.sv
// Purpose: sensor conditioning datapath, segmentation to filtered result
// Assumes: inputs synchronous to ref_clk, reset_n synchronous active low
// Notes:   divider is a restoring loop, one quotient bit per cycle
//          numerator and denominator carry 50 bits so that a full scale
//          coefficient shifted by 2(res-1) never overflows at 16 bits
//          pairs seen while raw acquisition runs are dropped, never kept
//          the gain numerator plus one needs four bits to reach eight
//
// Overview of operation
// - accept 13..16 bit results, map 15/16 down
// - diagnostic checks always shifted to 13 bits
// - temperature divided by 4 at 15/16 bits
// - bridge minus offset select times 2^13
// - segmentation only at 15/16 bits
// - raw acquisition returns unshifted corrected values
// - segmented bridge is 16-bit, wraps, no saturation
// - bridge and temperature treated as signed
// - Y is offset/temp numerator over gain denominator
// - P linearized with square and cube terms
// - eight coefficients from words 0 to 7
// - each new result written to output register
// - analog output has 5632 levels
// - readable result 15 bits, MSB error flag
// - filter adds scaled difference to previous output
// - first result after new command loads directly
// - both filter fields zero disable the filter
// - filter fields from bits 2:0 of words 8, 9
// - filter acts in normal run only
// - corrected raw is raw minus auto-zero

`timescale 1ns/100ps

module scdp_datapath #(
  parameter int RES_W = 16
) (
  // clock, reset, enable
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  // nonvolatile word writes
  input  wire logic        word_wr,
  input  wire logic [3:0]  word_idx,
  input  wire logic [15:0] word_wdata,
  output logic      [15:0] word_rdata,
  // configuration
  input  wire logic [4:0]  adc_resolution,
  input  wire logic [2:0]  bridge_offset_select,
  input  wire logic        raw_acquire_mode,
  input  wire logic        new_command,
  input  wire logic        error_flag,
  // conversion results from the front-end
  input  wire logic        conv_valid,
  input  wire logic [2:0]  conv_chan,
  input  wire logic [16:0] conv_raw,
  input  wire logic [16:0] conv_autozero,
  // results
  output logic      [15:0] serial_out_word,
  output logic             result_done,
  output logic      [12:0] dac_level,
  output logic      [15:0] raw_bridge_out,
  output logic      [15:0] raw_temp_out,
  output logic      [12:0] diag_value
);

  // ***************************************************************
  // elaboration checks
  // ***************************************************************
  if (RES_W != scdp_pkg::RES_MAX) begin : g_chk
    $error("scdp_datapath supports RES_W of 16 only");
  end

  // ***************************************************************
  // state
  // ***************************************************************
  typedef struct packed {
    logic [9:0][15:0]     words;
    scdp_pkg::scdp_state_t st;
    logic                 have_br;
    logic                 have_t;
    logic signed [16:0]   br;
    logic signed [16:0]   tv;
    logic signed [49:0]   num;
    logic signed [49:0]   den;
    logic        [49:0]   rem;
    logic        [14:0]   quo;
    logic        [4:0]    bitcnt;
    logic        [15:0]   pout;
    logic                 first;
    logic        [15:0]   out_word;
    logic                 done;
    logic        [15:0]   raw_br;
    logic        [15:0]   raw_t;
    logic        [12:0]   diag;
    logic        [12:0]   dac;
  } scdp_state_s_t;

  scdp_state_s_t cur_ff;
  scdp_state_s_t nxt_cur;

  logic        hi_res;
  logic [4:0]  res_m1;
  logic signed [16:0] zcorr;

  // resolution decode and auto-zero correction
  assign hi_res = (adc_resolution >= 5'(scdp_pkg::RES_SEG_MIN));
  assign res_m1 = adc_resolution - 5'd1;
  assign zcorr  = $signed(conv_raw) - $signed(conv_autozero);

  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb begin
    logic signed [16:0] seg_br;
    logic signed [16:0] seg_t;
    logic signed [33:0] t2;
    logic signed [49:0] nterm;
    logic signed [49:0] dterm;
    logic        [49:0] trial;
    logic        [29:0] y2;
    logic        [44:0] y3;
    logic signed [47:0] pacc;
    logic        [14:0] p15;
    logic signed [17:0] diff;
    logic signed [21:0] step;
    logic        [2:0]  fshift;
    logic        [2:0]  fgain;
    logic        [28:0] dprod;
    logic signed [49:0] co_off;
    logic signed [49:0] co_gain;
    logic signed [49:0] co_otc1;
    logic signed [49:0] co_otc2;
    logic signed [49:0] co_gtc1;
    logic signed [49:0] co_gtc2;
    logic signed [47:0] co_sq;
    logic signed [47:0] co_cu;
    // coefficients sign extended once from their words
    co_off  = 50'($signed(cur_ff.words[scdp_pkg::COND_COEF_OFFSET_IDX]));
    co_gain = 50'($signed(cur_ff.words[scdp_pkg::COND_COEF_GAIN_IDX]));
    co_otc1 = 50'($signed(cur_ff.words[scdp_pkg::COND_COEF_OFFSET_TC1_IDX]));
    co_otc2 = 50'($signed(cur_ff.words[scdp_pkg::COND_COEF_OFFSET_TC2_IDX]));
    co_gtc1 = 50'($signed(cur_ff.words[scdp_pkg::COND_COEF_GAIN_TC1_IDX]));
    co_gtc2 = 50'($signed(cur_ff.words[scdp_pkg::COND_COEF_GAIN_TC2_IDX]));
    co_sq   = 48'($signed(cur_ff.words[scdp_pkg::COND_COEF_SQUARE_IDX]));
    co_cu   = 48'($signed(cur_ff.words[scdp_pkg::COND_COEF_CUBE_IDX]));
    seg_br = '0;
    seg_t  = '0;
    t2     = '0;
    nterm  = '0;
    dterm  = '0;
    trial  = '0;
    y2     = '0;
    y3     = '0;
    pacc   = '0;
    p15    = '0;
    diff   = '0;
    step   = '0;
    dprod  = '0;
    nxt_cur = cur_ff;
    nxt_cur.done = 1'b0;
    // filter fields from words 8 and 9
    fshift = cur_ff.words[scdp_pkg::FILTER_SHIFT_WORD_IDX]
             [scdp_pkg::FILT_FIELD_LSB +: scdp_pkg::FILT_FIELD_W];
    fgain  = cur_ff.words[scdp_pkg::FILTER_GAIN_WORD_IDX]
             [scdp_pkg::FILT_FIELD_LSB +: scdp_pkg::FILT_FIELD_W];
    if (word_wr && (int'(word_idx) < scdp_pkg::NUM_WORDS)) begin
      nxt_cur.words[word_idx] = word_wdata;
    end
    if (new_command) begin
      nxt_cur.first = 1'b1;
    end
    // incoming results, segmented per channel
    if (conv_valid) begin
      if (conv_chan == scdp_pkg::SCDP_CH_DIAG) begin
        nxt_cur.diag = 13'(zcorr >>> (adc_resolution - 5'(scdp_pkg::DIAG_RES)));
      end else if (conv_chan == scdp_pkg::SCDP_CH_TEMP) begin
        nxt_cur.raw_t = 16'(zcorr);
        seg_t = hi_res ? (zcorr >>> scdp_pkg::TEMP_DIV_SHIFT) : zcorr;
        nxt_cur.tv = seg_t;
        nxt_cur.have_t = 1'b1;
      end else if (conv_chan == scdp_pkg::SCDP_CH_BRIDGE) begin
        nxt_cur.raw_br = 16'(zcorr);
        seg_br = hi_res ? (zcorr - $signed({1'b0, bridge_offset_select,
                 13'h0000})) : zcorr;
        // segmented value wraps in 16 bits
        nxt_cur.br = $signed({seg_br[15], seg_br[15:0]});
        nxt_cur.have_br = 1'b1;
      end
    end
    case (cur_ff.st)
      scdp_pkg::SCDP_IDLE: begin
        if (cur_ff.have_br && cur_ff.have_t && !raw_acquire_mode) begin
          t2 = cur_ff.tv * cur_ff.tv;
          // numerator and denominator scaled by 2^2(res-1), so the
          // fractional temperature terms stay exact integers
          nterm = (50'(cur_ff.br) + co_off) <<< (2 * res_m1);
          nterm = nterm + ((co_otc1 * 50'(cur_ff.tv)) <<< res_m1)
                  + co_otc2 * 50'(t2);
          dterm = (co_gain <<< (2 * res_m1))
                  + ((co_gtc1 * 50'(cur_ff.tv)) <<< res_m1)
                  + co_gtc2 * 50'(t2);
          nxt_cur.num    = nterm;
          nxt_cur.den    = dterm;
          nxt_cur.rem    = (nterm < 0) ? '0 : nterm;
          nxt_cur.quo    = '0;
          nxt_cur.bitcnt = 5'(scdp_pkg::FRAC_W);
          nxt_cur.have_br = 1'b0;
          nxt_cur.have_t  = 1'b0;
          nxt_cur.st = scdp_pkg::SCDP_DIV;
        end else if (raw_acquire_mode) begin
          // raw results never pair into a stale computation later
          nxt_cur.have_br = 1'b0;
          nxt_cur.have_t  = 1'b0;
        end
      end
      scdp_pkg::SCDP_DIV: begin
        // restoring division, Y clipped into [0,1)
        trial = 50'(cur_ff.rem << 1);
        if ((cur_ff.den > 0) && (trial >= cur_ff.den)) begin
          nxt_cur.rem = trial - cur_ff.den;
          nxt_cur.quo = {cur_ff.quo[13:0], 1'b1};
        end else begin
          nxt_cur.rem = trial;
          nxt_cur.quo = {cur_ff.quo[13:0], 1'b0};
        end
        if (cur_ff.rem >= cur_ff.den && cur_ff.bitcnt == 5'(scdp_pkg::FRAC_W)
            && cur_ff.den > 0) begin
          nxt_cur.quo = 15'h7fff;
          nxt_cur.st  = scdp_pkg::SCDP_LIN;
        end else begin
          nxt_cur.bitcnt = cur_ff.bitcnt - 5'd1;
          if (cur_ff.bitcnt == 5'd1) begin
            nxt_cur.st = scdp_pkg::SCDP_LIN;
          end
        end
      end
      scdp_pkg::SCDP_LIN: begin
        y2 = 30'(cur_ff.quo) * 30'(cur_ff.quo);
        y3 = 45'(y2[29:15]) * 45'(cur_ff.quo);
        pacc = (48'(cur_ff.quo) <<< scdp_pkg::LIN_SHIFT)
             - co_sq * 48'(cur_ff.quo)
             - co_cu * 48'(cur_ff.quo)
             + co_sq * 48'(y2[29:15])
             + co_cu * 48'(y3[29:15]);
        if (pacc < 0) begin
          p15 = '0;
        end else if (pacc[47:30] != '0) begin
          p15 = 15'h7fff;
        end else begin
          p15 = pacc[29:15];
        end
        // averaging filter
        diff = $signed({3'b000, p15}) - $signed({2'b00, cur_ff.pout});
        // gain plus one reaches eight, so it is kept in four bits
        step = (22'(diff) * $signed({18'h0_0000, 4'(fgain) + 4'd1}))
               >>> fshift;
        if (cur_ff.first || (fgain == 3'd0 && fshift == 3'd0)) begin
          nxt_cur.pout = {1'b0, p15};
          nxt_cur.first = new_command;
        end else begin
          nxt_cur.pout = 16'(22'(cur_ff.pout) + step);
        end
        nxt_cur.st = scdp_pkg::SCDP_OUT;
      end
      scdp_pkg::SCDP_OUT: begin
        nxt_cur.out_word = {error_flag, cur_ff.pout[14:0]};
        dprod = 29'(cur_ff.pout[14:0]) * 29'(scdp_pkg::DAC_LEVELS);
        nxt_cur.dac = dprod[27:15];
        nxt_cur.done = 1'b1;
        nxt_cur.st = scdp_pkg::SCDP_IDLE;
      end
      default: begin
        nxt_cur.st = scdp_pkg::SCDP_IDLE;
      end
    endcase
  end

  // ***************************************************************
  // state register
  // ***************************************************************
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      cur_ff       <= '0;
      cur_ff.st    <= scdp_pkg::SCDP_IDLE;
      cur_ff.first <= 1'b1;
    end else if (clk_en) begin
      cur_ff <= nxt_cur;
    end
  end

  // outputs from flip-flops, word_rdata muxed by word_idx
  assign word_rdata      = (int'(word_idx) < scdp_pkg::NUM_WORDS) ?
                           cur_ff.words[word_idx] : scdp_pkg::WORD_RESET;
  assign serial_out_word = cur_ff.out_word;
  assign result_done     = cur_ff.done;
  assign dac_level       = cur_ff.dac;
  assign raw_bridge_out  = cur_ff.raw_br;
  assign raw_temp_out    = cur_ff.raw_t;
  assign diag_value      = cur_ff.diag;

  // ***************************************************************
  // assertions
  // ***************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  done_after_out_a: assert property (clk_en && cur_ff.st == scdp_pkg::SCDP_OUT
    |=> result_done) else $error("done missing after output");
  done_pulse_a: assert property (result_done |=> !result_done || $past(clk_en) == 0)
    else $error("done not a pulse");
  err_bit_a: assert property (clk_en && cur_ff.st == scdp_pkg::SCDP_OUT
    |=> serial_out_word[15] == $past(error_flag))
    else $error("error bit wrong");
  start_both_a: assert property (cur_ff.st == scdp_pkg::SCDP_IDLE && clk_en
    ##1 cur_ff.st == scdp_pkg::SCDP_DIV |-> $past(cur_ff.have_br)
    && $past(cur_ff.have_t)) else $error("start without inputs");
  raw_br_a: assert property (clk_en && conv_valid
    && conv_chan == scdp_pkg::SCDP_CH_BRIDGE |=> raw_bridge_out
    == $past(16'(zcorr))) else $error("raw bridge altered");
  temp_div_a: assert property (clk_en && conv_valid && hi_res
    && conv_chan == scdp_pkg::SCDP_CH_TEMP |=> cur_ff.tv
    == ($past(zcorr) >>> 2)) else $error("temp not divided");
  temp_pass_a: assert property (clk_en && conv_valid && !hi_res
    && conv_chan == scdp_pkg::SCDP_CH_TEMP |=> cur_ff.tv == $past(zcorr))
    else $error("temp altered at low res");
  word_wr_a: assert property (clk_en && word_wr && word_idx == 4'h8
    |=> cur_ff.words[8] == $past(word_wdata))
    else $error("word write lost");
  dac_range_a: assert property (result_done |-> dac_level < 13'd5632)
    else $error("dac level out of range");
  sign_clear_a: assert property (result_done |-> cur_ff.pout[15] == 1'b0)
    else $error("filter output negative");

  // raw acquisition and segmentation paths
  raw_block_a: assert property (clk_en && raw_acquire_mode
    && cur_ff.st == scdp_pkg::SCDP_IDLE |=> cur_ff.st == scdp_pkg::SCDP_IDLE)
    else $error("computation started in raw mode");
  raw_temp_a: assert property (clk_en && conv_valid
    && conv_chan == scdp_pkg::SCDP_CH_TEMP |=> raw_temp_out
    == $past(16'(zcorr))) else $error("raw temperature altered");
  diag_shift_a: assert property (clk_en && conv_valid
    && conv_chan == scdp_pkg::SCDP_CH_DIAG |=> diag_value
    == 13'($past(zcorr) >>> ($past(adc_resolution)
    - 5'(scdp_pkg::DIAG_RES)))) else $error("diagnostic shift wrong");
  bridge_pass_a: assert property (clk_en && conv_valid && !hi_res
    && conv_chan == scdp_pkg::SCDP_CH_BRIDGE |=> cur_ff.br == $past(zcorr))
    else $error("bridge altered at low res");
  seg_wrap_a: assert property (clk_en && conv_valid
    && conv_chan == scdp_pkg::SCDP_CH_BRIDGE |=> cur_ff.br[16] == cur_ff.br[15])
    else $error("segmented bridge not 16 bit");
  // divider and control
  div_count_a: assert property (cur_ff.st == scdp_pkg::SCDP_DIV
    |-> cur_ff.bitcnt != 5'd0) else $error("divider count empty");
  clip_one_a: assert property (clk_en && cur_ff.st == scdp_pkg::SCDP_DIV
    && cur_ff.bitcnt == 5'd15 && cur_ff.den > 0 && cur_ff.rem >= cur_ff.den
    |=> cur_ff.quo == 15'h7fff) else $error("quotient not clipped");
  first_set_a: assert property (clk_en && new_command
    |=> cur_ff.first) else $error("first flag not set");
  state_hot_a: assert property ($onehot(cur_ff.st))
    else $error("state not one-hot");
  freeze_a: assert property (!clk_en |=> $stable(cur_ff))
    else $error("state moved while disabled");
  word_high_a: assert property (clk_en && word_wr && word_idx > 4'h9
    |=> $stable(cur_ff.words)) else $error("word beyond nine written");

  cov_result_c: cover property (result_done);
  cov_hires_c: cover property (result_done && hi_res);
  cov_filter_c: cover property (result_done && !cur_ff.first
    && cur_ff.words[8][2:0] != 3'd0);
  cov_diag_c: cover property (conv_valid && conv_chan == scdp_pkg::SCDP_CH_DIAG);
  cov_raw_c: cover property (raw_acquire_mode && conv_valid);

endmodule : scdp_datapath

// >>> test/scdp_adc_model.sv
// Purpose: front-end model that hands conversion results to the datapath
// Assumes: the bench calls convert just after a rising edge, gap >= 1
// Notes:   data lines carry inverted values between conversions
`timescale 1ns/100ps

module scdp_adc_model (
  // clock
  input  wire logic        ref_clk,
  // conversion results
  output logic             conv_valid,
  output logic      [2:0]  conv_chan,
  output logic      [16:0] conv_raw,
  output logic      [16:0] conv_autozero
);
  // idle lines start at a non-zero pattern
  initial begin
    conv_valid    = 1'b0;
    conv_chan     = 3'b000;
    conv_raw      = 17'h1_5555;
    conv_autozero = 17'h0_aaaa;
  end

  // one conversion after gap idle cycles, raw carries the auto-zero level
  task automatic convert(input logic [2:0] chan, input int corr, az, gap);
    repeat (gap) @(posedge ref_clk);
    conv_valid    <= 1'b1;
    conv_chan     <= chan;
    conv_raw      <= 17'(corr + az);
    conv_autozero <= 17'(az);
    @(posedge ref_clk);
    conv_valid    <= 1'b0;
    conv_chan     <= ~chan;
    conv_raw      <= ~conv_raw;
    conv_autozero <= ~conv_autozero;
  endtask : convert
endmodule : scdp_adc_model

// >>> test/scdp_datapath_test.sv
// Purpose: self-checking bench for the conditioning datapath
// Assumes: 10 MHz ref_clk, reset_n low for 8 cycles
// Notes:   random stimulus from seed 92, corner cases among it
`timescale 1ns/100ps

module scdp_datapath_test;
  logic        ref_clk, reset_n, clk_en, word_wr, new_command, err_v;
  logic        raw_acquire_mode, error_flag, conv_valid, result_done;
  logic [3:0]  word_idx;
  logic [15:0] word_wdata, word_rdata, serial_out_word;
  logic [15:0] raw_bridge_out, raw_temp_out;
  logic [4:0]  adc_resolution;
  logic [2:0]  bridge_offset_select, conv_chan;
  logic [16:0] conv_raw, conv_autozero;
  logic [12:0] dac_level, diag_value;
  int          miscompares, checks_done, seed, res, off, c0, c1, c4;
  int          i, p1, p2, pf;
  int          fs[4] = '{1, 2, 3, 2};
  int          fg[4] = '{0, 1, 7, 3};

  scdp_datapath #(.RES_W(16)) i_dut (.ref_clk, .reset_n, .clk_en,
    .word_wr, .word_idx, .word_wdata, .word_rdata, .adc_resolution,
    .bridge_offset_select, .raw_acquire_mode, .new_command, .error_flag,
    .conv_valid, .conv_chan, .conv_raw, .conv_autozero, .serial_out_word,
    .result_done, .dac_level, .raw_bridge_out, .raw_temp_out, .diag_value);
  scdp_adc_model i_adc (.ref_clk, .conv_valid, .conv_chan, .conv_raw,
    .conv_autozero);

  // ****************************************************************
  // tasks and expectations
  // ****************************************************************
  task automatic check_word(input logic [15:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : check_word

  task automatic complete_run;
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run

  task automatic write_word(input int idx, data);
    @(posedge ref_clk);
    word_wr    <= 1'b1;
    word_idx   <= 4'(idx);
    word_wdata <= 16'(data);
    @(posedge ref_clk);
    word_wr    <= 1'b0;
  endtask : write_word

  task automatic set_coefs;
    write_word(0, c0);
    write_word(1, c1);
    write_word(4, c4);
  endtask : set_coefs

  // segmentation, then Y clipped to [0,1) with square and cube at zero
  function automatic int exp_p(int b, int t);
    int num;
    if (res >= 15) begin
      b = shortint'(b - off * 8192);
      t = t / 4;
    end
    num = b + c0 + ((c4 * t) >>> (res - 1));
    if (num < 0)
      return 0;
    if (num >= c1)
      return 32767;
    return int'((longint'(num) <<< 15) / c1);
  endfunction : exp_p

  task automatic check_out(input int p);
    check_word(serial_out_word, {err_v, 15'(p)});
    check_word({3'b000, dac_level}, 16'((p * 5632) >> 15));
  endtask : check_out

  // one bridge and temperature pair in either order, clk_en stalls
  task automatic run_pair(input int b, t, input logic nc, want,
                          output int p);
    int   az, k;
    logic sw;
    az = $unsigned($random(seed)) % 64;
    sw = $random(seed);
    p  = exp_p(b, t);
    @(posedge ref_clk);
    adc_resolution       <= 5'(res);
    bridge_offset_select <= 3'(off);
    error_flag           <= err_v;
    new_command          <= nc;
    @(posedge ref_clk);
    new_command <= 1'b0;
    i_adc.convert(sw ? 3'b010 : 3'b001, sw ? t : b, az,
                  1 + $unsigned($random(seed)) % 4);
    i_adc.convert(sw ? 3'b001 : 3'b010, sw ? b : t, az, 1);
    k = 0;
    while (result_done !== 1'b1 && k < 120) begin
      @(posedge ref_clk);
      clk_en <= (($random(seed) & 3) != 0) || !want;
      @(negedge ref_clk);
      k++;
    end
    @(posedge ref_clk);
    clk_en <= 1'b1;
    check_word(16'(k < 120), 16'(want));
    check_word(raw_bridge_out, 16'(b));
    check_word(raw_temp_out, 16'(t));
  endtask : run_pair

  // ****************************************************************
  // clock, watchdog and main sequence
  // ****************************************************************
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // cut a hang short well beyond the expected run length
  initial begin
    #(100 * 20000);
    miscompares++;
    complete_run();
  end

  initial begin
    seed = 92;
    miscompares = 0;
    checks_done = 0;
    reset_n = 1'b0;
    clk_en = 1'b1;
    word_wr = 1'b0;
    word_idx = 4'h0;
    word_wdata = 16'h0000;
    adc_resolution = 5'h10;
    bridge_offset_select = 3'h0;
    raw_acquire_mode = 1'b0;
    new_command = 1'b0;
    error_flag = 1'b0;
    err_v = 1'b0;
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    // reset values, then write and read back every index
    for (i = 0; i < 16; i++) begin
      @(posedge ref_clk);
      word_idx <= 4'(i);
      @(negedge ref_clk);
      check_word(word_rdata, scdp_pkg::WORD_RESET);
    end
    check_word(serial_out_word, 16'h0000);
    for (i = 0; i < 16; i++) begin
      c0 = $random(seed);
      write_word(i, c0);
      @(negedge ref_clk);
      check_word(word_rdata, i < 10 ? 16'(c0) : 16'h0000);
    end
    for (i = 2; i < 10; i++)
      if (i != 4)
        write_word(i, 0);
    // diagnostic channel at every resolution
    for (res = 13; res < 17; res++) begin
      p1 = $unsigned($random(seed)) % (1 << (res - 1));
      @(posedge ref_clk);
      adc_resolution <= 5'(res);
      i_adc.convert(3'b100, p1, 5, 1);
      @(negedge ref_clk);
      check_word({3'b000, diag_value}, 16'(p1 >> (res - 13)));
    end
    // random conditioning runs, filter off; wrap and clip corners first
    for (i = 0; i < 24; i++) begin
      res = i == 0 ? 16 : 13 + $unsigned($random(seed)) % 4;
      off = i == 0 ? 0 : $unsigned($random(seed)) % (res == 15 ? 4 : 8);
      c0 = $random(seed) % 512;
      c1 = i == 1 ? 1000 : 8192 + $unsigned($random(seed)) % 16384;
      c4 = res < 16 ? 1 << (res - 1) : 0;
      err_v = $random(seed);
      set_coefs();
      p1 = i == 0 ? 40000 : $random(seed) % 4096;
      p1 = res >= 15 && i > 0 ? p1 + off * 8192 : p1;
      run_pair(p1, 4 * ($random(seed) % (1 << (res - 4))), 1'b1, 1'b1, p2);
      check_out(p2);
    end
    // raw acquisition blocks the conditioning result
    raw_acquire_mode <= 1'b1;
    run_pair(1234, 88, 1'b1, 1'b0, p2);
    raw_acquire_mode <= 1'b0;
    // filter settings, first result after a command loads directly
    res = 14;
    off = 0;
    c0 = 0;
    c1 = 16384;
    c4 = 0;
    set_coefs();
    for (i = 0; i < 4; i++) begin
      write_word(8, ($random(seed) & 'hfff8) | fs[i]);
      write_word(9, ($random(seed) & 'hfff8) | fg[i]);
      run_pair(1000 + i * 100, 0, 1'b1, 1'b1, p1);
      check_out(p1);
      run_pair(5000 + i * 1000, 0, 1'b0, 1'b1, p2);
      pf = p1 + (((p2 - p1) * (fg[i] + 1)) >>> fs[i]);
      check_out(pf);
    end
    complete_run();
  end
endmodule : scdp_datapath_test
